// File: bench/path_monitor_sva.sv
/* Concurrent checks on the fault monitor ports.
   Assumes the monitor's port names and its lift and power counts. */
`timescale 1ns/100ps
`default_nettype none
module path_monitor_sva #(
  parameter [31:0] LIFT_CYC  = 32'h0000_0028,
  parameter [31:0] POWER_CYC = 32'h0000_0032
) (
  input wire        CLOCK_I,
  input wire        RST_N_I,
  input wire        DRAWER_PRESENT_I,
  input wire        TRAY_TOP_SENSOR_I,
  input wire        TRAY_LIFT_MOTOR_O,
  input wire        REGISTRATION_SENSOR_I,
  input wire        FUSER_TRANSPORT_SENSOR_I,
  input wire        INTERMEDIATE_TRANSPORT_SENSOR_I,
  input wire        POWER_BUTTON_I,
  input wire        COPY_INHIBIT_O,
  input wire        COPY_STOP_O,
  input wire [15:0] ERROR_CODE_O,
  input wire        POWER_ON_O
);
  reg [31:0] press_cnt;
  reg [31:0] lift_cnt;
  reg        after_rst;
  // ********
  // Helpers
  // ********
  // Press length is kept after release, so a toggle on release is judged too.
  always @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      press_cnt <= 32'h0000_0000;
      lift_cnt  <= 32'h0000_0000;
      after_rst <= 1'h1;
    end else begin
      press_cnt <= $rose(POWER_BUTTON_I) ? 32'h0000_0001 :
                   POWER_BUTTON_I ? press_cnt + 32'h0000_0001 : press_cnt;
      lift_cnt  <= TRAY_LIFT_MOTOR_O ? lift_cnt + 32'h0000_0001 : 32'h0000_0000;
      after_rst <= 1'h0;
    end
  end
  // ********
  // Checks
  // ********
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);
  sequence s_no_drawer;
    !DRAWER_PRESENT_I [*3];
  endsequence
  sequence s_boot_busy;
    after_rst && (FUSER_TRANSPORT_SENSOR_I || REGISTRATION_SENSOR_I ||
                  INTERMEDIATE_TRANSPORT_SENSOR_I);
  endsequence
  a_no_drawer_lift: assert property (s_no_drawer |-> !TRAY_LIFT_MOTOR_O)
    else $error("lift motor runs without a drawer");
  a_no_drawer_inhibit: assert property (s_no_drawer |-> COPY_INHIBIT_O)
    else $error("start not inhibited without a drawer");
  a_top_stops_lift: assert property (TRAY_TOP_SENSOR_I [*3] |-> !TRAY_LIFT_MOTOR_O)
    else $error("lift motor runs with tray at top");
  a_lift_bounded: assert property (lift_cnt <= LIFT_CYC + 3)
    else $error("lift motor runs past its timeout");
  a_power_press: assert property ($changed(POWER_ON_O) |-> press_cnt >= POWER_CYC - 2)
    else $error("power toggled after a short press");
  a_bypass_inhibit: assert property ($rose(ERROR_CODE_O == 16'hE120) |-> ##[0:2] COPY_INHIBIT_O)
    else $error("bypass fault without inhibit");
  a_jam_stop: assert property ($rose(ERROR_CODE_O inside {16'hE010, 16'hE020}) |-> ##[0:2] COPY_STOP_O)
    else $error("edge jam without stop");
  a_residual_jam: assert property (s_boot_busy |-> ##[0:3] ERROR_CODE_O == 16'hE030)
    else $error("residual paper not flagged");
endmodule
bind paper_path_fault_monitor path_monitor_sva #(.LIFT_CYC(LIFT_CYC), .POWER_CYC(POWER_CYC)) chk_u (
  .CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .DRAWER_PRESENT_I(DRAWER_PRESENT_I),
  .TRAY_TOP_SENSOR_I(TRAY_TOP_SENSOR_I), .TRAY_LIFT_MOTOR_O(TRAY_LIFT_MOTOR_O),
  .REGISTRATION_SENSOR_I(REGISTRATION_SENSOR_I), .FUSER_TRANSPORT_SENSOR_I(FUSER_TRANSPORT_SENSOR_I),
  .INTERMEDIATE_TRANSPORT_SENSOR_I(INTERMEDIATE_TRANSPORT_SENSOR_I),
  .POWER_BUTTON_I(POWER_BUTTON_I), .COPY_INHIBIT_O(COPY_INHIBIT_O), .COPY_STOP_O(COPY_STOP_O),
  .ERROR_CODE_O(ERROR_CODE_O), .POWER_ON_O(POWER_ON_O));
`default_nettype wire

// File: bench/testbench.sv
/* Self-checking bench for the paper path fault monitor.
   Assumes the design header on the include path; short timeouts. */
`timescale 1ns/100ps
`default_nettype none
`include "paper_path_consts.vh"
module testbench;
  localparam [31:0] TMO = 32'h0000_001E;
  localparam [31:0] PWR = 32'h0000_0032;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        drawer, empty_sns, top, motor, drop, sol, byp_sns, fuser, button;
  logic        inhibit, stop, blink, power;
  logic [15:0] code;
  logic [10:0] misc;
  int          mismatches, total_checks;
  // Short timeouts; registration is longer so the intermediate jam wins.
  paper_path_fault_monitor #(.LIFT_CYC(32'h0000_0028), .PICK_CYC(TMO), .LEAD_CYC(TMO),
    .TRAIL_CYC(TMO), .REG_CYC(32'h0000_003C), .MID_CYC(TMO), .XPORT_CYC(TMO),
    .FEED_CYC(TMO), .POWER_CYC(PWR)) dut_u (
    .CLOCK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .DRAWER_PRESENT_I(drawer), .DRAWER_EMPTY_SENSOR_I(empty_sns),
    .TRAY_TOP_SENSOR_I(top), .TRAY_LIFT_MOTOR_O(motor), .BYPASS_PICKUP_SOLENOID_I(sol),
    .BYPASS_PAPER_SENSOR_I(byp_sns), .REGISTRATION_SENSOR_I(1'h0),
    .REGISTRATION_MOTOR_I(misc[0]), .FUSER_TRANSPORT_SENSOR_I(fuser),
    .INTERMEDIATE_TRANSPORT_SENSOR_I(misc[5]), .DRAWER_TRANSPORT_SENSOR_I(misc[4]),
    .DRAWER_FEED_SENSOR_I(misc[3]), .DRAWER_FEED_CLUTCH_I(misc[2]), .EXIT_SENSOR_I(misc[6]),
    .LOWER_COVER_OPEN_I(misc[1]), .DEVELOPER_CONNECTED_I(1'h1),
    .TONER_CARTRIDGE_EMPTY_SENSOR_I(misc[7]), .TONER_DENSITY_SENSOR_I(misc[8]),
    .CARTRIDGE_REPLACED_I(misc[9]), .WASTE_TONER_FULL_SENSOR_I(misc[10]),
    .POWER_BUTTON_I(button), .COPY_INHIBIT_O(inhibit), .COPY_STOP_O(stop),
    .DRAWER_BLINK_O(blink), .ERROR_CODE_O(code), .POWER_ON_O(power));
  tray_lift_model tray_u (.clk_i(clk), .motor_i(motor), .drop_i(drop), .top_o(top));
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  // ********
  // Shared tasks
  // ********
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Waits on pready rather than assuming zero wait states.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    q = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ********
  // Scenarios
  // ********
  task automatic t_lift;
    cyc(20);
    chk("lift motor", 1'h0, motor);
    apb(1'h0, `OFS_STATUS, 32'h0);
    chk("paper", 1'h1, q[`ST_PAPER]);
    apb(1'h1, `OFS_CTRL, 32'h1);
    drop <= 1'h1;
    cyc(1);
    drop <= 1'h0;
    cyc(4);
    chk("relift", 1'h1, motor);
    cyc(20);
    chk("relift stop", 1'h0, motor);
    empty_sns <= 1'h0;
    cyc(5);
    chk("blink", 1'h1, blink);
    chk("paper out stop", 1'h1, stop);
    empty_sns <= 1'h1;
    apb(1'h1, `OFS_CTRL, 32'h0);
    $display("lift test done");
  endtask
  task automatic t_nodrawer;
    drawer <= 1'h0;
    drop <= 1'h1;
    cyc(1);
    drop <= 1'h0;
    cyc(5);
    chk("no drawer lift", 1'h0, motor);
    chk("no drawer inhibit", 1'h1, inhibit);
    apb(1'h0, `OFS_STATUS, 32'h0);
    chk("add paper", 1'h1, q[`ST_ADD_PAPER]);
    drawer <= 1'h1;
    cyc(20);
    $display("drawer test done");
  endtask
  // Each entry raises one sensor or actuator line and never its successor.
  task automatic t_jams;
    logic [15:0] c[5] = '{`CODE_LEAD, `CODE_COVER, `CODE_FEED, `CODE_XPORT, `CODE_MID_DRW};
    for (int i = 0; i < 5; i++) begin
      apb(1'h1, `OFS_CTRL, 32'h1);
      misc[i] <= 1'h1;
      cyc(TMO + 8);
      chk("jam code", c[i], code);
      chk("jam stop", 1'h1, stop);
      misc[i] <= 1'h0;
      apb(1'h1, `OFS_CTRL, 32'h8);
      cyc(3);
      chk("jam clear", 16'h0, code);
    end
    $display("jam test done");
  endtask
  task automatic t_bypass;
    apb(1'h1, `OFS_CTRL, 32'h3);
    byp_sns <= 1'h1;
    sol <= 1'h1;
    cyc(TMO + 8);
    chk("bypass code", `CODE_BYPASS, code);
    chk("bypass inhibit", 1'h1, inhibit);
    sol <= 1'h0;
    byp_sns <= 1'h0;
    cyc(4);
    apb(1'h0, `OFS_STATUS, 32'h0);
    chk("bypass clear", 1'h0, q[`ST_BYPASS_FAULT]);
    apb(1'h1, `OFS_CTRL, 32'h0);
    $display("bypass test done");
  endtask
  task automatic t_power;
    button <= 1'h1;
    cyc(PWR - 10);
    button <= 1'h0;
    cyc(4);
    chk("short press", 1'h0, power);
    button <= 1'h1;
    cyc(PWR + 5);
    button <= 1'h0;
    cyc(4);
    chk("long press", 1'h1, power);
    $display("power test done");
  endtask
  task automatic t_regs;
    apb(1'h0, 12'h010, 32'h0);
    chk("unmapped error", 1'h1, err);
    chk("unmapped data", 32'h0, q);
    misc[10:7] <= 4'hB;
    cyc(3);
    misc[10] <= 1'h0;
    apb(1'h0, `OFS_STATUS, 32'h0);
    chk("bag full", 1'h1, q[`ST_BAG_FULL]);
    chk("toner out", 1'h1, q[`ST_TONER_OUT]);
    apb(1'h1, `OFS_BAG_COUNT, 32'h0);
    apb(1'h0, `OFS_STATUS, 32'h0);
    chk("bag cleared", 1'h0, q[`ST_BAG_FULL]);
    $display("register test done");
  endtask
  task automatic t_residual;
    fuser <= 1'h1;
    rst_n <= 1'h0;
    cyc(2);
    rst_n <= 1'h1;
    cyc(5);
    chk("residual", `CODE_RESIDUAL, code);
    fuser <= 1'h0;
    apb(1'h1, `OFS_CTRL, 32'h8);
    $display("residual test done");
  endtask
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, drop, sol, byp_sns, fuser, button} = '0;
    {drawer, empty_sns, misc, mismatches, total_checks} = {2'h3, 11'h0, 64'h0};
    cyc(16);
    rst_n <= 1'h1;
    t_lift;
    t_nodrawer;
    t_jams;
    t_bypass;
    t_power;
    t_regs;
    t_residual;
    report_and_stop;
  end
  // Whole run is near five hundred cycles; forty times that means a hang.
  initial begin
    cyc(20000);
    mismatches++;
    report_and_stop;
  end
endmodule
`default_nettype wire

// File: bench/tray_lift_model.sv
/* Tray lift mechanics seen by the monitor: the tray top sensor.
   Assumes one clock shared with the monitor. */
`timescale 1ns/100ps
`default_nettype none
module tray_lift_model #(
  parameter int RISE = 10
) (
  input  wire logic clk_i,
  input  wire logic motor_i,
  input  wire logic drop_i,
  output var  logic top_o
);
  int cnt = 0;
  initial top_o = 1'h0;
  // The tray climbs while the motor runs; a drop models paper used up.
  always @(posedge clk_i) begin
    if (drop_i) begin
      top_o <= 1'h0;
    end else if (motor_i) begin
      cnt <= cnt + 1;
      if (cnt >= RISE) top_o <= 1'h1;
    end else begin
      cnt <= 0;
    end
  end
endmodule
`default_nettype wire

// File: core/paper_path_consts.vh
/*
 * Constants for the paper path fault monitor: APB register offsets, field
 * positions, reset values, fault codes and timeout cycle counts.
 * Assumes a 250 MHz system clock; included by bare name.
 */
`ifndef PAPER_PATH_CONSTS_VH
`define PAPER_PATH_CONSTS_VH

// ***********************************************************************
// Register offsets (byte addresses).
// ***********************************************************************
`define OFS_CTRL        12'h000
`define OFS_STATUS      12'h004
`define OFS_CODE        12'h008
`define OFS_BAG_COUNT   12'h00C

// ***********************************************************************
// Control register fields.
// ***********************************************************************
`define CTRL_COPY       0
`define CTRL_BYPASS     1
`define CTRL_FEED_INIT  2
`define CTRL_CLEAR_JAM  3
`define CTRL_RESET      32'h0000_0000

// ***********************************************************************
// Status register fields.
// ***********************************************************************
`define ST_PAPER        0
`define ST_TRAY_BAD     1
`define ST_ADD_PAPER    2
`define ST_BYPASS_FAULT 3
`define ST_JAM          4
`define ST_DEV_MISSING  5
`define ST_TONER_OUT    6
`define ST_BAG_FULL     7
`define ST_INHIBIT      8
`define ST_STOP         9
`define ST_POWER        10
`define ST_BLINK        11

// ***********************************************************************
// Fault codes (hexadecimal digits as shown on the panel).
// ***********************************************************************
`define CODE_NONE       16'h0000
`define CODE_BYPASS     16'hE120
`define CODE_LEAD       16'hE010
`define CODE_TRAIL      16'hE020
`define CODE_RESIDUAL   16'hE030
`define CODE_COVER      16'hE410
`define CODE_REG_DRW    16'hE200
`define CODE_REG_BYP    16'hE110
`define CODE_REG_OTHER  16'hE3C0
`define CODE_MID_DRW    16'hE201
`define CODE_MID_OTHER  16'hE2A1
`define CODE_XPORT      16'hE230
`define CODE_FEED       16'hE130

// ***********************************************************************
// Timeouts: time in milliseconds and derived 250 MHz cycle counts.
// ***********************************************************************
`define CLK_KHZ         250000
`define T_LIFT_MS       5000
`define T_PICK_MS       500
`define T_LEAD_MS       800
`define T_TRAIL_MS      800
`define T_REG_MS        400
`define T_MID_MS        400
`define T_XPORT_MS      300
`define T_FEED_MS       300
`define T_POWER_MS      1000
`define CYC(ms)         ((ms) * `CLK_KHZ)

`endif

// File: core/paper_path_fault_monitor.v
/*
 * Paper path fault monitor: tray lift control, paper presence, bypass
 * pickup, jam timeouts, developer and toner faults and power button.
 * Assumes all sensor inputs are synchronous and active high, except
 * DRAWER_EMPTY_SENSOR_I, which is high while paper is present, and an APB
 * master on the same 250 MHz clock.
 */
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "paper_path_consts.vh"

module paper_path_fault_monitor #(
  parameter [31:0] LIFT_CYC  = `CYC(`T_LIFT_MS),
  parameter [31:0] PICK_CYC  = `CYC(`T_PICK_MS),
  parameter [31:0] LEAD_CYC  = `CYC(`T_LEAD_MS),
  parameter [31:0] TRAIL_CYC = `CYC(`T_TRAIL_MS),
  parameter [31:0] REG_CYC   = `CYC(`T_REG_MS),
  parameter [31:0] MID_CYC   = `CYC(`T_MID_MS),
  parameter [31:0] XPORT_CYC = `CYC(`T_XPORT_MS),
  parameter [31:0] FEED_CYC  = `CYC(`T_FEED_MS),
  parameter [31:0] POWER_CYC = `CYC(`T_POWER_MS)
) (
  input  wire        CLOCK_I,
  input  wire        RST_N_I,
  input  wire        PSEL_I,
  input  wire        PENABLE_I,
  input  wire        PWRITE_I,
  input  wire [11:0] PADDR_I,
  input  wire [31:0] PWDATA_I,
  output reg  [31:0] PRDATA_O,
  output wire        PREADY_O,
  output wire        PSLVERR_O,
  input  wire        DRAWER_PRESENT_I,
  input  wire        DRAWER_EMPTY_SENSOR_I,
  input  wire        TRAY_TOP_SENSOR_I,
  output reg         TRAY_LIFT_MOTOR_O,
  input  wire        BYPASS_PICKUP_SOLENOID_I,
  input  wire        BYPASS_PAPER_SENSOR_I,
  input  wire        REGISTRATION_SENSOR_I,
  input  wire        REGISTRATION_MOTOR_I,
  input  wire        FUSER_TRANSPORT_SENSOR_I,
  input  wire        INTERMEDIATE_TRANSPORT_SENSOR_I,
  input  wire        DRAWER_TRANSPORT_SENSOR_I,
  input  wire        DRAWER_FEED_SENSOR_I,
  input  wire        DRAWER_FEED_CLUTCH_I,
  input  wire        EXIT_SENSOR_I,
  input  wire        LOWER_COVER_OPEN_I,
  input  wire        DEVELOPER_CONNECTED_I,
  input  wire        TONER_CARTRIDGE_EMPTY_SENSOR_I,
  input  wire        TONER_DENSITY_SENSOR_I,
  input  wire        CARTRIDGE_REPLACED_I,
  input  wire        WASTE_TONER_FULL_SENSOR_I,
  input  wire        POWER_BUTTON_I,
  output wire        COPY_INHIBIT_O,
  output wire        COPY_STOP_O,
  output reg         DRAWER_BLINK_O,
  output reg  [15:0] ERROR_CODE_O,
  output reg         POWER_ON_O
);

  // ***********************************************************************
  // Timeout helper.
  // ***********************************************************************

  // Next value of an interval counter: cleared on start, counts while armed.
  function [31:0] tick;
    input [31:0] cnt;
    input        start;
    input        armed;
    begin
      if (start) begin
        tick = 32'h0000_0000;
      end else if (armed && cnt != 32'hFFFF_FFFF) begin
        tick = cnt + 32'h0000_0001;
      end else begin
        tick = cnt;
      end
    end
  endfunction

  // ***********************************************************************
  // Register bus.
  // ***********************************************************************
  reg  [31:0] ctrl;
  reg  [15:0] bag_count;
  wire        wr_en   = PSEL_I && PENABLE_I && PWRITE_I;
  wire        copying = ctrl[`CTRL_COPY];
  wire        bypass  = ctrl[`CTRL_BYPASS];
  wire        mapped  = (PADDR_I == `OFS_CTRL) || (PADDR_I == `OFS_STATUS) ||
                        (PADDR_I == `OFS_CODE) || (PADDR_I == `OFS_BAG_COUNT);

  // Zero wait states; unmapped addresses answer with an error.
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;

  // ***********************************************************************
  // State.
  // ***********************************************************************
  localparam [1:0] LIFT_IDLE = 2'b00;
  localparam [1:0] LIFT_UP   = 2'b01;
  localparam [1:0] LIFT_DONE = 2'b10;
  localparam [1:0] LIFT_BAD  = 2'b11;

  reg  [1:0]  lift_state;
  reg  [31:0] lift_cnt, pick_cnt, lead_cnt, trail_cnt, reg_cnt, mid_cnt;
  reg  [31:0] xport_cnt, feed_cnt, power_cnt;
  reg         paper, tray_bad, bypass_fault, jam, dev_missing, toner_out;
  reg         toner_warned, bag_full, bag_stop, power_seen, power_up_chk;
  reg         reg_motor_d, xport_d, feed_d, clutch_d, pick_d, reg_armed;
  reg         mid_armed, xport_armed, feed_armed, lead_armed, trail_armed;
  wire        add_paper = !DRAWER_PRESENT_I || tray_bad || !paper;
  wire [31:0] status;

  assign status = {20'h0_0000, DRAWER_BLINK_O, POWER_ON_O, COPY_STOP_O,
                   COPY_INHIBIT_O, bag_full, toner_out, dev_missing, jam,
                   bypass_fault, add_paper, tray_bad, paper};

  // Start is refused for missing drawer paper outside bypass, bypass pickup fault, jam, developer missing and toner out.
  assign COPY_INHIBIT_O = (add_paper && !bypass) || bypass_fault || jam ||
                          dev_missing || toner_out;
  // Stop is immediate for jams and paper out; bag full waits for exit.
  assign COPY_STOP_O = jam || (copying && !bypass && add_paper) || bag_stop;

  // Read data path registered so it is stable during the access phase.
  always @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PRDATA_O <= 32'h0000_0000;
    end else if (PSEL_I && !PENABLE_I) begin
      if (PADDR_I == `OFS_CTRL) begin
        PRDATA_O <= ctrl;
      end else if (PADDR_I == `OFS_STATUS) begin
        PRDATA_O <= status;
      end else if (PADDR_I == `OFS_CODE) begin
        PRDATA_O <= {16'h0000, ERROR_CODE_O};
      end else if (PADDR_I == `OFS_BAG_COUNT) begin
        PRDATA_O <= {16'h0000, bag_count};
      end else begin
        PRDATA_O <= 32'h0000_0000;
      end
    end
  end

  // Control register; feed init and clear jam are self clearing strobes.
  always @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctrl <= `CTRL_RESET;
    end else if (wr_en && PADDR_I == `OFS_CTRL) begin
      ctrl <= PWDATA_I;
    end else begin
      ctrl[`CTRL_FEED_INIT] <= 1'b0;
      ctrl[`CTRL_CLEAR_JAM] <= 1'b0;
    end
  end

  // ***********************************************************************
  // Tray lift and paper presence.
  // ***********************************************************************

  // The lift never runs without a drawer, and a timed-out lift stays failed
  // until reset, because the tray mechanism cannot be trusted.
  always @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      lift_state        <= LIFT_UP;
      lift_cnt          <= 32'h0000_0000;
      TRAY_LIFT_MOTOR_O <= 1'b0;
      paper             <= 1'b0;
      tray_bad          <= 1'b0;
      DRAWER_BLINK_O    <= 1'b0;
    end else begin
      lift_cnt <= tick(lift_cnt, lift_state != LIFT_UP || !DRAWER_PRESENT_I, 1'b1);
      case (lift_state)
        LIFT_IDLE: begin
          TRAY_LIFT_MOTOR_O <= 1'b0;
          if (ctrl[`CTRL_FEED_INIT]) begin
            lift_state <= LIFT_UP;
          end
        end
        LIFT_UP: begin
          if (!DRAWER_PRESENT_I) begin
            TRAY_LIFT_MOTOR_O <= 1'b0;
            paper             <= 1'b0;
          end else if (TRAY_TOP_SENSOR_I) begin
            TRAY_LIFT_MOTOR_O <= 1'b0;
            paper             <= DRAWER_EMPTY_SENSOR_I;
            lift_state        <= LIFT_DONE;
          end else if (lift_cnt >= LIFT_CYC) begin
            TRAY_LIFT_MOTOR_O <= 1'b0;
            tray_bad          <= 1'b1;
            lift_state        <= LIFT_BAD;
          end else begin
            TRAY_LIFT_MOTOR_O <= 1'b1;
          end
        end
        LIFT_DONE: begin
          if (!DRAWER_PRESENT_I || ctrl[`CTRL_FEED_INIT]) begin
            TRAY_LIFT_MOTOR_O <= 1'b0;
            lift_state        <= LIFT_UP;
          end else begin
            // Top-up during copying as the stack shrinks.
            TRAY_LIFT_MOTOR_O <= copying && !TRAY_TOP_SENSOR_I;
            if (copying && TRAY_TOP_SENSOR_I && !DRAWER_EMPTY_SENSOR_I) begin
              paper          <= 1'b0;
              DRAWER_BLINK_O <= !bypass;
            end else if (TRAY_TOP_SENSOR_I && DRAWER_EMPTY_SENSOR_I) begin
              paper          <= 1'b1;
              DRAWER_BLINK_O <= 1'b0;
            end
          end
        end
        default: begin
          TRAY_LIFT_MOTOR_O <= 1'b0;
        end
      endcase
    end
  end

  // ***********************************************************************
  // Jam and bypass timeouts.
  // ***********************************************************************

  // One counter per watched interval; each restarts on its start edge, reg_cnt and mid_cnt on the same one.
  always @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pick_cnt <= 32'h0000_0000;
      lead_cnt <= 32'h0000_0000;
      trail_cnt <= 32'h0000_0000;
      reg_cnt <= 32'h0000_0000;
      mid_cnt <= 32'h0000_0000;
      xport_cnt <= 32'h0000_0000;
      feed_cnt <= 32'h0000_0000;
      reg_motor_d <= 1'b0;
      xport_d <= 1'b0;
      feed_d <= 1'b0;
      clutch_d <= 1'b0;
      pick_d <= 1'b0;
      reg_armed <= 1'b0;
      mid_armed <= 1'b0;
      xport_armed <= 1'b0;
      feed_armed <= 1'b0;
      lead_armed <= 1'b0;
      trail_armed <= 1'b0;
      bypass_fault <= 1'b0;
      jam <= 1'b0;
      ERROR_CODE_O <= `CODE_NONE;
      power_up_chk <= 1'b1;
    end else begin
      reg_motor_d <= REGISTRATION_MOTOR_I;
      xport_d     <= DRAWER_TRANSPORT_SENSOR_I;
      feed_d      <= DRAWER_FEED_SENSOR_I;
      clutch_d    <= DRAWER_FEED_CLUTCH_I;
      pick_d      <= BYPASS_PICKUP_SOLENOID_I;
      power_up_chk <= 1'b0;
      pick_cnt  <= tick(pick_cnt, BYPASS_PICKUP_SOLENOID_I && !pick_d, 1'b1);
      lead_cnt  <= tick(lead_cnt, REGISTRATION_MOTOR_I && !reg_motor_d, lead_armed);
      trail_cnt <= tick(trail_cnt, !REGISTRATION_MOTOR_I && reg_motor_d, trail_armed);
      reg_cnt   <= tick(reg_cnt, DRAWER_TRANSPORT_SENSOR_I && !xport_d, reg_armed);
      mid_cnt   <= tick(mid_cnt, DRAWER_TRANSPORT_SENSOR_I && !xport_d, mid_armed);
      xport_cnt <= tick(xport_cnt, DRAWER_FEED_SENSOR_I && !feed_d, xport_armed);
      feed_cnt  <= tick(feed_cnt, DRAWER_FEED_CLUTCH_I && !clutch_d, feed_armed);
      // Arm on the start edge, disarm when the awaited sensor answers.
      if (REGISTRATION_MOTOR_I && !reg_motor_d) begin
        lead_armed <= 1'b1;
      end else if (FUSER_TRANSPORT_SENSOR_I) begin
        lead_armed <= 1'b0;
      end
      if (!REGISTRATION_MOTOR_I && reg_motor_d) begin
        trail_armed <= 1'b1;
      end else if (!FUSER_TRANSPORT_SENSOR_I) begin
        trail_armed <= 1'b0;
      end
      if (DRAWER_TRANSPORT_SENSOR_I && !xport_d) begin
        reg_armed <= 1'b1;
        mid_armed <= 1'b1;
      end else begin
        if (REGISTRATION_SENSOR_I) begin
          reg_armed <= 1'b0;
        end
        if (INTERMEDIATE_TRANSPORT_SENSOR_I) begin
          mid_armed <= 1'b0;
        end
      end
      if (DRAWER_FEED_SENSOR_I && !feed_d) begin
        xport_armed <= 1'b1;
      end else if (DRAWER_TRANSPORT_SENSOR_I) begin
        xport_armed <= 1'b0;
      end
      if (DRAWER_FEED_CLUTCH_I && !clutch_d) begin
        feed_armed <= 1'b1;
      end else if (DRAWER_FEED_SENSOR_I) begin
        feed_armed <= 1'b0;
      end
      if (ctrl[`CTRL_CLEAR_JAM]) begin
        {lead_armed, trail_armed, reg_armed, mid_armed, xport_armed, feed_armed} <= 6'h00;
      end
      // Bypass pickup fault: cleared by emptying the tray, set wins.
      if (bypass && BYPASS_PICKUP_SOLENOID_I && !REGISTRATION_SENSOR_I &&
          pick_cnt >= PICK_CYC) begin
        bypass_fault <= 1'b1;
        ERROR_CODE_O <= `CODE_BYPASS;
      end else if (!BYPASS_PAPER_SENSOR_I) begin
        bypass_fault <= 1'b0;
      end
      // The first jam latches its code until cleared; a bypass fault can overwrite the code.
      if (power_up_chk && (REGISTRATION_SENSOR_I || FUSER_TRANSPORT_SENSOR_I ||
          INTERMEDIATE_TRANSPORT_SENSOR_I || DRAWER_TRANSPORT_SENSOR_I ||
          DRAWER_FEED_SENSOR_I || EXIT_SENSOR_I)) begin
        jam <= 1'b1;
        ERROR_CODE_O <= `CODE_RESIDUAL;
      end else if (!jam && copying && LOWER_COVER_OPEN_I) begin
        jam <= 1'b1;
        ERROR_CODE_O <= `CODE_COVER;
      end else if (!jam && lead_armed && lead_cnt >= LEAD_CYC) begin
        jam <= 1'b1;
        ERROR_CODE_O <= `CODE_LEAD;
      end else if (!jam && trail_armed && trail_cnt >= TRAIL_CYC) begin
        jam <= 1'b1;
        ERROR_CODE_O <= `CODE_TRAIL;
      end else if (!jam && reg_armed && reg_cnt >= REG_CYC) begin
        jam <= 1'b1;
        ERROR_CODE_O <= bypass ? `CODE_REG_BYP : `CODE_REG_DRW;
      end else if (!jam && mid_armed && mid_cnt >= MID_CYC) begin
        jam <= 1'b1;
        ERROR_CODE_O <= `CODE_MID_DRW;
      end else if (!jam && xport_armed && xport_cnt >= XPORT_CYC) begin
        jam <= 1'b1;
        ERROR_CODE_O <= `CODE_XPORT;
      end else if (!jam && feed_armed && feed_cnt >= FEED_CYC) begin
        jam <= 1'b1;
        ERROR_CODE_O <= `CODE_FEED;
      end else if (jam && ctrl[`CTRL_CLEAR_JAM] && !LOWER_COVER_OPEN_I) begin
        jam <= 1'b0;
        ERROR_CODE_O <= `CODE_NONE;
      end
    end
  end

  // ***********************************************************************
  // Developer, toner, bag and power button.
  // ***********************************************************************

  // Supply faults and the power toggle, which needs a full one-second hold
  // so that a brushed button does not switch the machine.
  always @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      dev_missing  <= 1'b0;
      toner_warned <= 1'b0;
      toner_out    <= 1'b0;
      bag_full     <= 1'b0;
      bag_stop     <= 1'b0;
      bag_count    <= 16'h0000;
      power_cnt    <= 32'h0000_0000;
      power_seen   <= 1'b0;
      POWER_ON_O   <= 1'b0;
    end else begin
      if (!DEVELOPER_CONNECTED_I) begin
        dev_missing <= 1'b1;
      end else if (!LOWER_COVER_OPEN_I) begin
        dev_missing <= 1'b0;
      end
      if (CARTRIDGE_REPLACED_I) begin
        toner_warned <= 1'b0;
        toner_out    <= 1'b0;
      end else begin
        if (TONER_CARTRIDGE_EMPTY_SENSOR_I) begin
          toner_warned <= 1'b1;
        end
        if (toner_warned && TONER_DENSITY_SENSOR_I) begin
          toner_out <= 1'b1;
        end
      end
      // Bag full: sensor sets; zeroing the service counter clears.
      if (wr_en && PADDR_I == `OFS_BAG_COUNT) begin
        bag_count <= PWDATA_I[15:0];
      end else if (WASTE_TONER_FULL_SENSOR_I && !bag_full &&
                   bag_count != 16'hFFFF) begin
        bag_count <= bag_count + 16'h0001;
      end
      if (WASTE_TONER_FULL_SENSOR_I) begin
        bag_full <= 1'b1;
      end else if (wr_en && PADDR_I == `OFS_BAG_COUNT && PWDATA_I[15:0] == 16'h0000) begin
        bag_full <= 1'b0;
      end
      // Stop waits for the sheet in progress to leave the exit.
      if (bag_full && (!copying || EXIT_SENSOR_I == 1'b0 && !REGISTRATION_MOTOR_I &&
          !FUSER_TRANSPORT_SENSOR_I)) begin
        bag_stop <= 1'b1;
      end else if (!bag_full) begin
        bag_stop <= 1'b0;
      end
      power_cnt <= tick(power_cnt, !POWER_BUTTON_I, 1'b1);
      if (!POWER_BUTTON_I) begin
        power_seen <= 1'b0;
      end else if (power_cnt >= POWER_CYC && !power_seen) begin
        power_seen <= 1'b1;
        POWER_ON_O <= !POWER_ON_O;
      end
    end
  end

endmodule
`default_nettype wire
